/* File: tdsensor_defs.svh */
// Timing and multiplier constants for the temperature-to-delay line sensor.
// Assumes a 50 MHz core clock.
`ifndef TDSENSOR_DEFS_SVH
`define TDSENSOR_DEFS_SVH

`define CLK_PERIOD_PS 20000
// Glitch filter width: 500 ns, rounded up
`define GLITCH_NS 500
`define GLITCH_CYC ((`GLITCH_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Reset width: 16 ms longest; scaled per microsecond to stay inside 32-bit math
`define RESET_US 16000
`define RESET_CYC (`RESET_US * `US_CYC)
// Self-return to ready: 520 ms longest
`define READY_US 520000
`define READY_CYC (`READY_US * `US_CYC)
// One microsecond in clock cycles
`define US_CYC (1000000 / `CLK_PERIOD_PS)
// Low pulse width factor, us per kelvin
`define LOW_MULT 5
// Multipliers, us per kelvin
`define MULT_L0 5
`define MULT_L1 20
`define MULT_L2 40
`define MULT_L3 80
`define MULT_H0 160
`define MULT_H1 320
`define MULT_H2 480
`define MULT_H3 640

`endif

/* File: tdsensor_pkg.sv */
// Types for the temperature-to-delay line sensor.
// Used with tdsensor_defs.svh.
package tdsensor_pkg;
    typedef enum logic [3:0] {
        ST_READY = 4'h1,
        ST_DELAY = 4'h2,
        ST_PULSE = 4'h4,
        ST_WAIT = 4'h8
    } seq_state_t;
endpackage

/* File: line_sample_if.sv */
// Filtered line level and falling edge passed from the line filter.
// Driven by line_filter, read by the sequencer.
`timescale 1ns/10ps
interface line_sample_if;
    logic level;
    logic fall;
    modport src (output level, output fall);
    modport dst (input level, input fall);
endinterface

/* File: line_filter.sv */
// Synchroniser and glitch filter for the shared line input.
// Line is asynchronous to clock_i.
`timescale 1ns/10ps
`include "tdsensor_defs.svh"
module line_filter (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Raw line
    input wire logic line_i,
    // Filtered result
    line_sample_if.src smp
);
    localparam int GW = `GLITCH_CYC;
    logic sync1_ff;
    logic sync2_ff;
    logic [5:0] cnt_ff;
    logic lvl_ff;
    logic fall_ff;
    wire differ = (sync2_ff != lvl_ff);
    wire settle = differ && (cnt_ff == 6'(GW - 1));

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
        end
        else
        begin
            sync1_ff <= line_i;
            sync2_ff <= sync1_ff;
        end
    end

    // Level must persist a full filter width before it is accepted
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_ff <= 6'h00;
            lvl_ff <= 1'b1;
            fall_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= (differ && !settle) ? cnt_ff + 6'h01 : 6'h00;
            lvl_ff <= settle ? sync2_ff : lvl_ff;
            fall_ff <= settle && !sync2_ff;
        end
    end

    assign smp.level = lvl_ff;
    assign smp.fall = fall_ff;

    chk_glitch_reject: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $fell(lvl_ff) |-> $past(sync2_ff, GW) == 1'b0)
        else $error("line accepted low before filter width");
endmodule

/* File: temp_delay_single_wire_sensor.sv */
// Temperature-to-delay sensor sequencer on one open-drain line.
// Kelvin temperature arrives as a word from the analog side.
`timescale 1ns/10ps
`include "tdsensor_defs.svh"

// What this block does
// - After reset the sensor waits in ready for a trigger.
// - Line is only pulled low; released otherwise, pull-up keeps it high.
// - Host pulls low then releases; sensor owns the next low pulse.
// - Timing starts at the trigger's falling edge.
// - Sensor pulls low after multiplier times kelvin microseconds.
// - Sensor holds the line low five microseconds per kelvin.
// - Line held low past reset width returns sensor to ready.
// - Sensor returns to ready by itself within 520 ms of trigger.
// - Low range straps select 5, 20, 40, 80.
// - High range straps select 160, 320, 480, 640.
// - Low glitches shorter than 500 ns are ignored.
module temp_delay_single_wire_sensor #(
    parameter int RESET_CYCLES = `RESET_CYC,
    parameter int READY_CYCLES = `READY_CYC
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Shared line
    input wire logic line_i,
    output logic line_o,
    output logic line_oe_o,
    // Straps and variant
    input wire logic mult_select_hi_i,
    input wire logic mult_select_lo_i,
    input wire logic high_range_i,
    // Kelvin temperature word
    input wire logic [9:0] kelvin_i,
    // Status
    output logic busy_o
);
    //--------------------------------------------------------------
    // Input sampling
    //--------------------------------------------------------------
    line_sample_if smp ();
    line_filter u_filter (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .line_i(line_i),
        .smp(smp)
    );

    logic [2:0] sel_s1_ff;
    logic [2:0] sel_s2_ff;
    logic [9:0] kel_s1_ff;
    logic [9:0] kel_s2_ff;
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sel_s1_ff <= 3'h0;
            sel_s2_ff <= 3'h0;
            kel_s1_ff <= 10'h000;
            kel_s2_ff <= 10'h000;
        end
        else
        begin
            sel_s1_ff <= {high_range_i, mult_select_hi_i, mult_select_lo_i};
            sel_s2_ff <= sel_s1_ff;
            kel_s1_ff <= kelvin_i;
            kel_s2_ff <= kel_s1_ff;
        end
    end

    //--------------------------------------------------------------
    // Multiplier select
    //--------------------------------------------------------------
    logic [9:0] mult_w;
    always_comb
    begin
        case (sel_s2_ff)
            3'h0: mult_w = 10'(`MULT_L0);
            3'h1: mult_w = 10'(`MULT_L1);
            3'h2: mult_w = 10'(`MULT_L2);
            3'h3: mult_w = 10'(`MULT_L3);
            3'h4: mult_w = 10'(`MULT_H0);
            3'h5: mult_w = 10'(`MULT_H1);
            3'h6: mult_w = 10'(`MULT_H2);
            default: mult_w = 10'(`MULT_H3);
        endcase
    end

    //--------------------------------------------------------------
    // Sequencer
    //--------------------------------------------------------------
    localparam int USC = `US_CYC;
    tdsensor_pkg::seq_state_t state_ff;
    tdsensor_pkg::seq_state_t nxt_state;
    logic [5:0] us_ff;
    logic [19:0] usec_ff;
    logic [19:0] target_ff;
    logic [19:0] low_len_ff;
    logic [31:0] ready_cnt_ff;
    logic [31:0] low_cnt_ff;
    logic drive_ff;
    logic busy_ff;

    wire us_tick = (us_ff == 6'(USC - 1));
    wire long_low = (low_cnt_ff >= 32'(RESET_CYCLES));
    wire self_rst = (ready_cnt_ff >= 32'(READY_CYCLES - 1));
    wire host_low = !smp.level && !drive_ff;
    wire in_ready = (state_ff == tdsensor_pkg::ST_READY);
    wire delay_done = (state_ff == tdsensor_pkg::ST_DELAY) && us_tick
        && (usec_ff + 20'h00001 >= target_ff);
    wire pulse_done = (state_ff == tdsensor_pkg::ST_PULSE) && us_tick
        && (usec_ff + 20'h00001 >= low_len_ff);
    wire [19:0] delay_calc = 20'(kel_s2_ff * mult_w);
    wire [19:0] low_calc = 20'(kel_s2_ff * 10'(`LOW_MULT));

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            tdsensor_pkg::ST_READY:
                if (smp.fall)
                    nxt_state = tdsensor_pkg::ST_DELAY;
            tdsensor_pkg::ST_DELAY:
                if (delay_done)
                    nxt_state = tdsensor_pkg::ST_PULSE;
            tdsensor_pkg::ST_PULSE:
                if (pulse_done)
                    nxt_state = tdsensor_pkg::ST_WAIT;
            tdsensor_pkg::ST_WAIT:
                nxt_state = tdsensor_pkg::ST_WAIT;
            default:
                nxt_state = tdsensor_pkg::ST_READY;
        endcase
        if (!in_ready && (long_low || self_rst))
            nxt_state = tdsensor_pkg::ST_READY;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state_ff <= tdsensor_pkg::ST_READY;
        else
            state_ff <= nxt_state;
    end

    // Microsecond prescaler and elapsed-microsecond count, restarted at trigger and again at pulse start
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            us_ff <= 6'h00;
            usec_ff <= 20'h00000;
        end
        else if (in_ready || delay_done)
        begin
            us_ff <= 6'h00;
            usec_ff <= 20'h00000;
        end
        else
        begin
            us_ff <= us_tick ? 6'h00 : us_ff + 6'h01;
            usec_ff <= us_tick ? usec_ff + 20'h00001 : usec_ff;
        end
    end

    // Targets latched at the trigger edge
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            target_ff <= 20'h00000;
            low_len_ff <= 20'h00000;
        end
        else if (in_ready && smp.fall)
        begin
            target_ff <= delay_calc;
            low_len_ff <= low_calc;
        end
    end

    // Self-return timer and host long-low timer
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ready_cnt_ff <= 32'h00000000;
            low_cnt_ff <= 32'h00000000;
        end
        else
        begin
            ready_cnt_ff <= in_ready ? 32'h00000000 : ready_cnt_ff + 32'h00000001;
            low_cnt_ff <= (host_low && !long_low) ? low_cnt_ff + 32'h00000001
                : (host_low ? low_cnt_ff : 32'h00000000);
        end
    end

    // Open-drain drive: only ever pulls low
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            drive_ff <= 1'b0;
            busy_ff <= 1'b0;
        end
        else
        begin
            drive_ff <= (nxt_state == tdsensor_pkg::ST_PULSE);
            busy_ff <= (nxt_state != tdsensor_pkg::ST_READY);
        end
    end

    assign line_oe_o = drive_ff;
    assign line_o = 1'b0;
    assign busy_o = busy_ff;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    chk_trigger_starts: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (in_ready && smp.fall) |=> (state_ff == tdsensor_pkg::ST_DELAY) && busy_o)
        else $error("trigger edge did not start timing");
    chk_drive_in_pulse: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        line_oe_o == (state_ff == tdsensor_pkg::ST_PULSE))
        else $error("drive does not match pulse state");
    chk_pulse_start: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $rose(line_oe_o) |-> $past(usec_ff) + 20'h00001 >= target_ff)
        else $error("response pulse started early");
    chk_long_low_abort: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (!in_ready && long_low) |=> in_ready)
        else $error("long low did not return to ready");
    chk_self_return: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ready_cnt_ff <= 32'(READY_CYCLES))
        else $error("self return overdue");
    chk_low_only: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        line_o == 1'b0)
        else $error("line driven high");
endmodule

/* File: host_line_model.sv */
// Host-side model of the shared line: triggers, aborts and times replies.
// Assumes the bench resolves the wire from both pull-downs and a pull-up.
`timescale 1ns/10ps
module host_line_model (
    // Clock
    input wire logic clock_i,
    // Line
    input wire logic line_i,
    output logic pull_low_o
);
    int cyc = 0;
    int t0 = 0;

    initial pull_low_o = 1'b0;

    always @(posedge clock_i) cyc <= cyc + 1;

    // Pull low for n cycles after an idle-high setup time
    task automatic drive_low(input int n);
        repeat (500) @(posedge clock_i);
        pull_low_o <= 1'b1;
        t0 = cyc;
        repeat (n) @(posedge clock_i);
        pull_low_o <= 1'b0;
    endtask

    // Reply delay from the trigger edge and reply width; -1 when missing
    task automatic time_reply(output int dly, output int wid);
        int i;
        dly = -1;
        wid = -1;
        @(posedge clock_i);
        for (i = 0; i < 40000 && line_i === 1'b1; i++) @(posedge clock_i);
        if (line_i === 1'b0)
        begin
            dly = cyc - t0;
            for (i = 0; i < 2000 && line_i === 1'b0; i++) @(posedge clock_i);
            if (line_i === 1'b1)
                wid = cyc - t0 - dly;
        end
    endtask
endmodule

/* File: temp_delay_single_wire_sensor_tb_top.sv */
// Self-checking bench for the temperature-to-delay line sensor.
// Assumes a 50 MHz clock; shortened reset and ready counts.
`timescale 1ns/10ps
module temp_delay_single_wire_sensor_tb_top;
    localparam int RST_CYC = 300;
    localparam int RDY_CYC = 33000;
    localparam int US = 50;
    int mult_tab[8] = '{5, 20, 40, 80, 160, 320, 480, 640};
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic sel_hi = 1'b0;
    logic sel_lo = 1'b0;
    logic hi_rng = 1'b0;
    logic [9:0] kelvin = 10'h001;
    logic line_o;
    logic line_oe_o;
    logic busy_o;
    logic host_low;
    wire logic line = !(host_low || (line_oe_o && !line_o));
    int n_mismatch = 0;
    int checks_done = 0;
    int d;
    int w;
    int k;
    int el;
    int i;

    always #10 clock_i = ~clock_i;

    // ----------------------------------------
    // Device and host
    // ----------------------------------------
    temp_delay_single_wire_sensor #(
        .RESET_CYCLES(RST_CYC),
        .READY_CYCLES(RDY_CYC)
    ) temp_delay_single_wire_sensor_inst (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .line_i(line),
        .line_o(line_o),
        .line_oe_o(line_oe_o),
        .mult_select_hi_i(sel_hi),
        .mult_select_lo_i(sel_lo),
        .high_range_i(hi_rng),
        .kelvin_i(kelvin),
        .busy_o(busy_o)
    );

    host_line_model host_line_model_inst (
        .clock_i(clock_i),
        .line_i(line),
        .pull_low_o(host_low)
    );

    // ----------------------------------------
    // Compare and report
    // ----------------------------------------
    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        checks_done++;
        if (g < lo || g > hi)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(62));
        repeat (12) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        chk_bit("busy after reset", 1'b0, busy_o);
        chk_bit("drive after reset", 1'b0, line_oe_o);
        chk_bit("drive value", 1'b0, line_o);
        host_line_model_inst.drive_low(1 + $urandom % 20);
        repeat (100) @(posedge clock_i);
        chk_bit("busy after glitch", 1'b0, busy_o);
        for (int c = 0; c < 8; c++)
        begin
            k = (c < 2) ? 1 + $urandom % 2 : 1;
            hi_rng <= c[2];
            sel_hi <= c[1];
            sel_lo <= c[0];
            kelvin <= k[9:0];
            host_line_model_inst.drive_low(100);
            host_line_model_inst.time_reply(d, w);
            if (d < 0)
            begin
                n_mismatch++;
                wrap_up;
            end
            chk_rng("delay", mult_tab[c] * k * US, mult_tab[c] * k * US + 40, d);
            chk_rng("width", 5 * k * US - 3, 5 * k * US + 3, w);
            chk_rng("kelvin", k, k, d / (mult_tab[c] * US));
            chk_bit("busy in run", 1'b1, busy_o);
            if (c < 7)
            begin
                host_line_model_inst.drive_low(RST_CYC + 50);
                repeat (50) @(posedge clock_i);
                chk_bit("busy after abort", 1'b0, busy_o);
            end
        end
        for (i = 0; i < RDY_CYC && busy_o === 1'b1; i++) @(posedge clock_i);
        el = host_line_model_inst.cyc - host_line_model_inst.t0;
        chk_rng("self return", RDY_CYC, RDY_CYC + 40, el);
        wrap_up;
    end
endmodule
